// ==== fpt_param_table.sv ====
// wishbone slave serving the discovery parameter table
`timescale 1ns/1ps
module fpt_param_table
  import fpt_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  input  wire logic        WE_I,
  input  wire logic [7:0]  ADR_I,
  input  wire logic [3:0]  SEL_I,
  input  wire logic [31:0] DAT_I,
  output logic      [31:0] DAT_O,
  output logic             ACK_O
);
  logic        ack_r;
  logic        ack_nxt;
  logic [31:0] dat_r;
  logic [31:0] dat_nxt;
  logic        req;
  logic        rd_req;
  logic [7:0]  wadr;
  logic        hit_tbl;
  logic        hit_info;
  logic        hit_bptr;
  logic        hit_bdat;
  logic [31:0] tbl_word;
  logic [31:0] str_word;
  logic [7:0]  ptr;
  logic [7:0]  str_byte;
  logic        ptr_load;
  logic        ptr_step;
  logic [31:0] info_word;

  // new request only when no answer is standing
  assign req    = CYC_I & STB_I & ~ack_r;
  assign rd_req = req & ~WE_I;
  assign wadr   = {ADR_I[7:2], 2'h0};

  // address decode
  assign hit_tbl  = (wadr >= FPT_TBL_BASE) &&
                    (wadr < FPT_TBL_END);
  assign hit_info = (wadr == FPT_OFF_INFO);
  assign hit_bptr = (wadr == FPT_OFF_BPTR);
  assign hit_bdat = (wadr == FPT_OFF_BDAT);

  // table words for the bus and for the byte stream
  fpt_table_rom u_rom_bus (
    .addr (wadr),
    .word (tbl_word)
  );

  fpt_table_rom u_rom_str (
    .addr (ptr),
    .word (str_word)
  );

  // streaming pointer: loaded by write, stepped by each byte read
  assign ptr_load = req & WE_I & hit_bptr & SEL_I[0];
  assign ptr_step = rd_req & hit_bdat;

  fpt_byte_ptr u_ptr (
    .clk      (CLK),
    .rst_n    (RST_N),
    .load     (ptr_load),
    .load_val (DAT_I[7:0]),
    .step     (ptr_step),
    .ptr      (ptr)
  );

  // byte lane picked by low pointer bits, low byte first
  assign str_byte = ptr[1:0] == 2'h0 ? str_word[7:0] :
                    ptr[1:0] == 2'h1 ? str_word[15:8] :
                    ptr[1:0] == 2'h2 ? str_word[23:16] :
                    str_word[31:24];

  // table location and length
  assign info_word = {16'h0000, FPT_TBL_WORDS, FPT_TBL_BASE};

  // read data selection, unmapped reads give zero
  assign dat_nxt = !rd_req ? dat_r :
                   hit_tbl ? tbl_word :
                   hit_info ? info_word :
                   hit_bptr ? {24'h000000, ptr} :
                   hit_bdat ? {24'h000000, str_byte} :
                   FPT_UNMAPPED;

  // one answer per request, dropped the cycle after
  assign ack_nxt = req;

  // bus answer registers
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ack_r <= 1'b0;
      dat_r <= FPT_UNMAPPED;
    end else begin
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
    end
  end

  assign ACK_O = ack_r;
  assign DAT_O = dat_r;

  // helpers for checks
  logic       rd_ack;
  logic [7:0] ptr_seen;
  assign rd_ack = ACK_O & CYC_I & STB_I & ~WE_I;

  always_ff @(posedge CLK) begin
    if (!RST_N) ptr_seen <= FPT_PTR_RST;
    else if (ptr_step) ptr_seen <= ptr;
  end

  // bus handshake timing, info word, table fields and byte stream
  AST_ACK_ONE: assert property (@(posedge CLK) disable iff (!RST_N)
    req |=> ACK_O ##1 !ACK_O)
    else $error("ack not one cycle after request");

  AST_INFO_BASE: assert property (@(posedge CLK) disable iff (!RST_N)
    rd_ack && wadr == FPT_OFF_INFO |-> DAT_O[7:0] == 8'h30)
    else $error("table base wrong");

  AST_INFO_LEN: assert property (@(posedge CLK) disable iff (!RST_N)
    rd_ack && wadr == FPT_OFF_INFO |-> DAT_O[15:8] == 8'h10)
    else $error("table length wrong");

  AST_PAST_END: assert property (@(posedge CLK) disable iff (!RST_N)
    rd_req && wadr >= 8'h70 && wadr < 8'h80 |=> DAT_O == 32'h0)
    else $error("read past table end not unmapped");

  AST_CAPS: assert property (@(posedge CLK) disable iff (!RST_N)
    rd_ack && wadr == 8'h30 |-> DAT_O[4:0] == 5'b00101)
    else $error("erase caps fields wrong");

  AST_READ_BITS: assert property (@(posedge CLK) disable iff (!RST_N)
    rd_ack && wadr == 8'h30 |-> DAT_O[22:16] == 7'b1111001)
    else $error("fast read support bits wrong");

  AST_DENSITY: assert property (@(posedge CLK) disable iff (!RST_N)
    rd_req && wadr == 8'h34 |=> DAT_O == 32'h01ffffff)
    else $error("density wrong");

  AST_Q144: assert property (@(posedge CLK) disable iff (!RST_N)
    rd_ack && wadr == 8'h38 |-> DAT_O[15:0] == 16'heb44)
    else $error("quad address read fields wrong");

  AST_Q114: assert property (@(posedge CLK) disable iff (!RST_N)
    rd_ack && wadr == 8'h38 |-> DAT_O[31:16] == 16'h6b08)
    else $error("quad output read fields wrong");

  AST_D112: assert property (@(posedge CLK) disable iff (!RST_N)
    rd_ack && wadr == 8'h3c |-> DAT_O[15:0] == 16'h3b08)
    else $error("dual output read fields wrong");

  AST_D122: assert property (@(posedge CLK) disable iff (!RST_N)
    rd_ack && wadr == 8'h3c |-> DAT_O[31:16] == 16'hbb80)
    else $error("dual address read fields wrong");

  AST_ALLDUAL: assert property (@(posedge CLK) disable iff (!RST_N)
    rd_ack && wadr == 8'h44 |-> DAT_O[31:16] == 16'hff00)
    else $error("all dual read not reported absent");

  AST_ALLDUAL_BIT: assert property (@(posedge CLK) disable iff (!RST_N)
    rd_ack && wadr == 8'h40 |-> !DAT_O[0])
    else $error("all dual support bit set");

  AST_ALLQUAD: assert property (@(posedge CLK) disable iff (!RST_N)
    rd_ack && wadr == 8'h48 |-> DAT_O[31:16] == 16'heb44)
    else $error("all quad read fields wrong");

  AST_ALLQUAD_BIT: assert property (@(posedge CLK) disable iff (!RST_N)
    rd_ack && wadr == 8'h40 |-> DAT_O[4])
    else $error("all quad support bit clear");

  AST_ERASE1: assert property (@(posedge CLK) disable iff (!RST_N)
    rd_ack && wadr == 8'h4c |-> DAT_O[15:0] == 16'h200c)
    else $error("erase type 1 wrong");

  AST_ERASE2: assert property (@(posedge CLK) disable iff (!RST_N)
    rd_ack && wadr == 8'h4c |-> DAT_O[31:16] == 16'h520f)
    else $error("erase type 2 wrong");

  AST_ERASE3: assert property (@(posedge CLK) disable iff (!RST_N)
    rd_ack && wadr == 8'h50 |-> DAT_O[15:0] == 16'hd810)
    else $error("erase type 3 wrong");

  AST_ERASE4: assert property (@(posedge CLK) disable iff (!RST_N)
    rd_ack && wadr == 8'h50 |-> DAT_O[31:16] == 16'hff00)
    else $error("erase type 4 not absent");

  AST_EMULT: assert property (@(posedge CLK) disable iff (!RST_N)
    rd_ack && wadr == 8'h54 |-> DAT_O[3:0] == 4'h3)
    else $error("erase multiplier wrong");

  AST_ET1: assert property (@(posedge CLK) disable iff (!RST_N)
    rd_ack && wadr == 8'h54 |-> DAT_O[10:4] == 7'b0100100)
    else $error("erase type 1 time wrong");

  AST_ET2: assert property (@(posedge CLK) disable iff (!RST_N)
    rd_ack && wadr == 8'h54 |-> DAT_O[17:11] == 7'b0100110)
    else $error("erase type 2 time wrong");

  AST_ET3: assert property (@(posedge CLK) disable iff (!RST_N)
    rd_ack && wadr == 8'h54 |-> DAT_O[24:18] == 7'b0101001)
    else $error("erase type 3 time wrong");

  AST_ET4: assert property (@(posedge CLK) disable iff (!RST_N)
    rd_ack && wadr == 8'h54 |-> DAT_O[31:25] == 7'h00)
    else $error("erase type 4 time not zero");

  AST_RESERVED: assert property (@(posedge CLK) disable iff (!RST_N)
    rd_req && wadr >= 8'h58 && wadr < 8'h70 |=> DAT_O == 32'hffffffff)
    else $error("reserved table word not ones");

  AST_STREAM_STEP: assert property (@(posedge CLK) disable iff (!RST_N)
    ptr_step && !ptr_load |=> ptr == 8'($past(ptr) + 8'h01))
    else $error("stream pointer did not advance");

  AST_STREAM_FIRST: assert property (@(posedge CLK) disable iff (!RST_N)
    ptr_step && ptr == 8'h30 |=> DAT_O == 32'h000000e5 ##1 ptr == 8'h31)
    else $error("stream first byte wrong");

  // answer only follows a taken request, data only moves on a read
  AST_ACK_CAUSE: assert property (@(posedge CLK) disable iff (!RST_N)
    ACK_O |-> $past(req))
    else $error("ack without request");

  AST_ACK_PULSE: assert property (@(posedge CLK) disable iff (!RST_N)
    ACK_O |=> !ACK_O)
    else $error("ack longer than one cycle");

  AST_DAT_HOLD: assert property (@(posedge CLK) disable iff (!RST_N)
    !rd_req |=> $stable(DAT_O))
    else $error("read data moved without a read");

  AST_WR_NO_DATA: assert property (@(posedge CLK) disable iff (!RST_N)
    req && WE_I |=> $stable(DAT_O))
    else $error("write changed read data");

  // reset returns bus and pointer to their idle state
  AST_RESET_STATE: assert property (@(posedge CLK) disable iff (!RST_N)
    $rose(RST_N) |-> !ACK_O && DAT_O == 32'h00000000 && ptr == 8'h30)
    else $error("state after reset wrong");

  // stream pointer load, hold and byte enable
  AST_PTR_LOAD: assert property (@(posedge CLK) disable iff (!RST_N)
    ptr_load |=> ptr == $past(DAT_I[7:0]))
    else $error("pointer not loaded");

  AST_PTR_HOLD: assert property (@(posedge CLK) disable iff (!RST_N)
    !ptr_load && !ptr_step |=> $stable(ptr))
    else $error("pointer moved while idle");

  AST_PTR_SEL: assert property (@(posedge CLK) disable iff (!RST_N)
    req && WE_I && hit_bptr && !SEL_I[0] |=> $stable(ptr))
    else $error("pointer written without byte enable");

  AST_BPTR_READ: assert property (@(posedge CLK) disable iff (!RST_N)
    rd_ack && wadr == 8'h84 |-> DAT_O == {24'h000000, ptr})
    else $error("pointer readback wrong");

  // streamed bytes: upper bits clear, low byte of each word first
  AST_STREAM_HI: assert property (@(posedge CLK) disable iff (!RST_N)
    rd_ack && wadr == 8'h88 |-> DAT_O[31:8] == 24'h000000)
    else $error("stream upper bits set");

  AST_STREAM_OUT: assert property (@(posedge CLK) disable iff (!RST_N)
    ptr_step && (ptr < 8'h30 || ptr >= 8'h70) |=> DAT_O == 32'h000000ff)
    else $error("stream outside table not ones");

  AST_STREAM_DENS: assert property (@(posedge CLK) disable iff (!RST_N)
    ptr_step && ptr == 8'h37 |=> DAT_O == 32'h00000001)
    else $error("stream density top byte wrong");

  AST_STREAM_LOW: assert property (@(posedge CLK) disable iff (!RST_N)
    ptr_step && ptr == 8'h54 |=> DAT_O == 32'h00000043)
    else $error("stream erase time low byte wrong");

  // reserved and unused fields read as ones
  AST_CAPS_UNUSED: assert property (@(posedge CLK) disable iff (!RST_N)
    rd_ack && wadr == 8'h30 |-> DAT_O[7:5] == 3'h7)
    else $error("caps unused bits not ones");

  AST_CAPS_RSVD: assert property (@(posedge CLK) disable iff (!RST_N)
    rd_ack && wadr == 8'h30 |-> DAT_O[31:23] == 9'h1ff)
    else $error("caps reserved bits not ones");

  AST_WIDE_RSVD: assert property (@(posedge CLK) disable iff (!RST_N)
    rd_ack && wadr == 8'h40 |-> DAT_O[31:5] == 27'h7ffffff &&
    DAT_O[3:1] == 3'h7)
    else $error("wide read reserved bits not ones");

  AST_ADRD_RSVD: assert property (@(posedge CLK) disable iff (!RST_N)
    rd_ack && wadr == 8'h44 |-> DAT_O[15:0] == 16'hffff)
    else $error("all dual reserved half not ones");

  AST_AQRD_RSVD: assert property (@(posedge CLK) disable iff (!RST_N)
    rd_ack && wadr == 8'h48 |-> DAT_O[15:0] == 16'hffff)
    else $error("all quad reserved half not ones");

  // remaining fields of the first word
  AST_CAPS_OP4K: assert property (@(posedge CLK) disable iff (!RST_N)
    rd_ack && wadr == 8'h30 |-> DAT_O[15:8] == 8'h20)
    else $error("small erase opcode wrong");

  AST_DTR_ABYTE: assert property (@(posedge CLK) disable iff (!RST_N)
    rd_ack && wadr == 8'h30 |-> DAT_O[19] && DAT_O[18:17] == 2'h0)
    else $error("dtr or address byte field wrong");

  // main scenarios
  COV_TBL_READ: cover property (@(posedge CLK) disable iff (!RST_N)
    rd_ack && hit_tbl);

  COV_PTR_LOAD: cover property (@(posedge CLK) disable iff (!RST_N)
    ptr_load ##[2:20] ptr_step);

  COV_STREAM_WORD: cover property (@(posedge CLK) disable iff (!RST_N)
    ptr_step && ptr_seen[1:0] == 2'h3 && ptr[1:0] == 2'h0);

  COV_UNMAPPED: cover property (@(posedge CLK) disable iff (!RST_N)
    rd_req && !hit_tbl && !hit_info && !hit_bptr && !hit_bdat);

  COV_STREAM_END: cover property (@(posedge CLK) disable iff (!RST_N)
    ptr_step && ptr == 8'h70);

endmodule : fpt_param_table

// ==== fpt_pkg.sv ====
// constants for the discovery parameter table block
package fpt_pkg;
  // wishbone byte offsets, table length in words, pointer reset value and fill words
  localparam logic [7:0]  FPT_TBL_BASE  = 8'h30;
  localparam logic [7:0]  FPT_TBL_WORDS = 8'h10;
  localparam logic [7:0]  FPT_TBL_END   = 8'h70;
  localparam logic [7:0]  FPT_OFF_CAPS  = 8'h30;
  localparam logic [7:0]  FPT_OFF_DENS  = 8'h34;
  localparam logic [7:0]  FPT_OFF_QRD   = 8'h38;
  localparam logic [7:0]  FPT_OFF_DRD   = 8'h3c;
  localparam logic [7:0]  FPT_OFF_WIDE  = 8'h40;
  localparam logic [7:0]  FPT_OFF_ADRD  = 8'h44;
  localparam logic [7:0]  FPT_OFF_AQRD  = 8'h48;
  localparam logic [7:0]  FPT_OFF_ER12  = 8'h4c;
  localparam logic [7:0]  FPT_OFF_ER34  = 8'h50;
  localparam logic [7:0]  FPT_OFF_ETIM  = 8'h54;
  localparam logic [7:0]  FPT_OFF_INFO  = 8'h80;
  localparam logic [7:0]  FPT_OFF_BPTR  = 8'h84;
  localparam logic [7:0]  FPT_OFF_BDAT  = 8'h88;
  localparam logic [7:0]  FPT_PTR_RST   = 8'h30;
  localparam logic [31:0] FPT_ONES      = 32'hffffffff;
  localparam logic [31:0] FPT_UNMAPPED  = 32'h00000000;
  // capability fields
  localparam logic [1:0]  FPT_ERSZ      = 2'h1;
  localparam logic [0:0]  FPT_WGRAN     = 1'h1;
  localparam logic [0:0]  FPT_VBP       = 1'h0;
  localparam logic [0:0]  FPT_WESEL     = 1'h0;
  localparam logic [1:0]  FPT_ABYTE     = 2'h0;
  localparam logic [0:0]  FPT_YES       = 1'h1;
  localparam logic [0:0]  FPT_NO        = 1'h0;
  // fast read fields: wait count, mode count, opcode
  localparam logic [4:0]  FPT_WAIT_144  = 5'h04;
  localparam logic [2:0]  FPT_MODE_144  = 3'h2;
  localparam logic [7:0]  FPT_OP_144    = 8'heb;
  localparam logic [4:0]  FPT_WAIT_11X  = 5'h08;
  localparam logic [2:0]  FPT_MODE_11X  = 3'h0;
  localparam logic [7:0]  FPT_OP_114    = 8'h6b;
  localparam logic [7:0]  FPT_OP_112    = 8'h3b;
  localparam logic [4:0]  FPT_WAIT_122  = 5'h00;
  localparam logic [2:0]  FPT_MODE_122  = 3'h4;
  localparam logic [7:0]  FPT_OP_122    = 8'hbb;
  localparam logic [7:0]  FPT_OP_NONE   = 8'hff;
  // erase types: size exponent and opcode
  localparam logic [7:0]  FPT_ESZ1 = 8'h0c;
  localparam logic [7:0]  FPT_EOP1 = 8'h20;
  localparam logic [7:0]  FPT_ESZ2 = 8'h0f;
  localparam logic [7:0]  FPT_EOP2 = 8'h52;
  localparam logic [7:0]  FPT_ESZ3 = 8'h10;
  localparam logic [7:0]  FPT_EOP3 = 8'hd8;
  localparam logic [7:0]  FPT_ESZ4 = 8'h00;
  // erase time fields
  localparam logic [3:0]  FPT_EMULT = 4'h3;
  localparam logic [4:0]  FPT_ET1   = 5'h04;
  localparam logic [4:0]  FPT_ET2   = 5'h06;
  localparam logic [4:0]  FPT_ET3   = 5'h09;
  localparam logic [4:0]  FPT_ET4   = 5'h00;
  localparam logic [1:0]  FPT_EUNIT = 2'h1;
  localparam logic [1:0]  FPT_EU4   = 2'h0;
  // assembled table words
  localparam logic [31:0] FPT_W_CAPS = {8'hff, 1'h1, FPT_YES, FPT_YES,
    FPT_YES, FPT_YES, FPT_ABYTE, FPT_YES, FPT_EOP1, 3'h7, FPT_WESEL,
    FPT_VBP, FPT_WGRAN, FPT_ERSZ};
  localparam logic [31:0] FPT_W_DENS = 32'h01ffffff;
  localparam logic [31:0] FPT_W_QRD  = {FPT_OP_114, FPT_MODE_11X,
    FPT_WAIT_11X, FPT_OP_144, FPT_MODE_144, FPT_WAIT_144};
  localparam logic [31:0] FPT_W_DRD  = {FPT_OP_122, FPT_MODE_122,
    FPT_WAIT_122, FPT_OP_112, FPT_MODE_11X, FPT_WAIT_11X};
  localparam logic [31:0] FPT_W_WIDE = {24'hffffff, 3'h7, FPT_YES, 3'h7,
    FPT_NO};
  localparam logic [31:0] FPT_W_ADRD = {FPT_OP_NONE, 8'h00, 16'hffff};
  localparam logic [31:0] FPT_W_AQRD = {FPT_OP_144, FPT_MODE_144,
    FPT_WAIT_144, 16'hffff};
  localparam logic [31:0] FPT_W_ER12 = {FPT_EOP2, FPT_ESZ2, FPT_EOP1,
    FPT_ESZ1};
  localparam logic [31:0] FPT_W_ER34 = {FPT_OP_NONE, FPT_ESZ4, FPT_EOP3,
    FPT_ESZ3};
  localparam logic [31:0] FPT_W_ETIM = {FPT_EU4, FPT_ET4, FPT_EUNIT,
    FPT_ET3, FPT_EUNIT, FPT_ET2, FPT_EUNIT, FPT_ET1, FPT_EMULT};
endpackage : fpt_pkg

// ==== fpt_table_rom.sv ====
// constant word lookup for the parameter table
`timescale 1ns/1ps
module fpt_table_rom
  import fpt_pkg::*;
(
  input  wire logic [7:0]  addr,
  output logic      [31:0] word
);
  logic [7:0] wa;

  // word-aligned address, reserved slots read as ones
  assign wa = {addr[7:2], 2'h0};

  always_comb begin
    if (wa == FPT_OFF_CAPS) word = FPT_W_CAPS;
    else if (wa == FPT_OFF_DENS) word = FPT_W_DENS;
    else if (wa == FPT_OFF_QRD) word = FPT_W_QRD;
    else if (wa == FPT_OFF_DRD) word = FPT_W_DRD;
    else if (wa == FPT_OFF_WIDE) word = FPT_W_WIDE;
    else if (wa == FPT_OFF_ADRD) word = FPT_W_ADRD;
    else if (wa == FPT_OFF_AQRD) word = FPT_W_AQRD;
    else if (wa == FPT_OFF_ER12) word = FPT_W_ER12;
    else if (wa == FPT_OFF_ER34) word = FPT_W_ER34;
    else if (wa == FPT_OFF_ETIM) word = FPT_W_ETIM;
    else word = FPT_ONES;
  end
endmodule : fpt_table_rom

// ==== fpt_byte_ptr.sv ====
// byte read pointer for streaming the table
`timescale 1ns/1ps
module fpt_byte_ptr
  import fpt_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       load,
  input  wire logic [7:0] load_val,
  input  wire logic       step,
  output logic      [7:0] ptr
);
  logic [7:0] ptr_r;
  logic [7:0] ptr_nxt;

  // load wins over step, step moves to next byte
  assign ptr_nxt = load ? load_val :
                   step ? 8'(ptr_r + 8'h01) : ptr_r;

  // pointer register
  always_ff @(posedge clk) begin
    if (!rst_n) ptr_r <= FPT_PTR_RST;
    else ptr_r <= ptr_nxt;
  end

  assign ptr = ptr_r;
endmodule : fpt_byte_ptr

// ==== fpt_host_model.sv ====
// wishbone master model standing in for the host that reads the table
`timescale 1ns/1ps
module fpt_host_model (
  input  wire logic        clk,
  output logic             cyc,
  output logic             stb,
  output logic             we,
  output logic [7:0]       adr,
  output logic [3:0]       sel,
  output logic [31:0]      dat_w,
  input  wire logic [31:0] dat_r,
  input  wire logic        ack
);
  int timeouts;

  // idle bus at time zero
  initial begin
    cyc      <= 1'b0;
    stb      <= 1'b0;
    we       <= 1'b0;
    adr      <= 8'h00;
    sel      <= 4'h0;
    dat_w    <= 32'h00000000;
    timeouts = 0;
  end

  // one classic cycle; gap idles first to act as a slow host
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [3:0] s, input logic [31:0] d,
                      input int gap, output logic [31:0] q);
    int n;
    repeat (gap + 1) @(posedge clk);
    cyc   <= 1'b1;
    stb   <= 1'b1;
    we    <= w;
    adr   <= a;
    sel   <= s;
    dat_w <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 16);
    if (ack !== 1'b1) timeouts++;
    q = dat_r;
    // released lines show junk, not the last value
    cyc   <= 1'b0;
    stb   <= 1'b0;
    we    <= ~w;
    adr   <= ~a;
    sel   <= ~s;
    dat_w <= ~d;
  endtask : xfer
endmodule : fpt_host_model

// ==== flash_parameter_table_rom_tb.sv ====
// self-checking bench for the discovery parameter table
`timescale 1ns/1ps
module flash_parameter_table_rom_tb;
  import fpt_pkg::*;
  logic        CLK;
  logic        RST_N;
  logic        CYC_I;
  logic        STB_I;
  logic        WE_I;
  logic [7:0]  ADR_I;
  logic [3:0]  SEL_I;
  logic [31:0] DAT_I;
  logic [31:0] DAT_O;
  logic        ACK_O;
  logic [31:0] q;
  int          bad_count;
  int          samples_checked;

  // expected table words, worked out field by field
  localparam logic [31:0] EXP_W [16] = '{
    32'hfff920e5,
    32'h01ffffff,
    32'h6b08eb44,
    32'hbb803b08,
    32'hfffffffe,
    32'hff00ffff,
    32'heb44ffff,
    32'h520f200c,
    32'hff00d810,
    32'h00a53243,
    32'hffffffff, 32'hffffffff, 32'hffffffff,
    32'hffffffff, 32'hffffffff, 32'hffffffff
  };

  fpt_param_table dut_u (
    .CLK   (CLK),
    .RST_N (RST_N),
    .CYC_I (CYC_I),
    .STB_I (STB_I),
    .WE_I  (WE_I),
    .ADR_I (ADR_I),
    .SEL_I (SEL_I),
    .DAT_I (DAT_I),
    .DAT_O (DAT_O),
    .ACK_O (ACK_O)
  );

  fpt_host_model host_u (
    .clk   (CLK),
    .cyc   (CYC_I),
    .stb   (STB_I),
    .we    (WE_I),
    .adr   (ADR_I),
    .sel   (SEL_I),
    .dat_w (DAT_I),
    .dat_r (DAT_O),
    .ack   (ACK_O)
  );

  // 10 MHz clock
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end

  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic rd(input logic [7:0] a, input int gap,
                    output logic [31:0] d);
    host_u.xfer(1'b0, a, 4'hf, 32'h00000000, gap, d);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d);
    logic [31:0] unused_q;
    host_u.xfer(1'b1, a, s, d, 0, unused_q);
  endtask : wr

  // verdict and end of run
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize

  // cut a hang short, well beyond the expected run
  initial begin
    #400000;
    bad_count++;
    summarize();
  end

  // main sequence
  initial begin
    bad_count = 0;
    samples_checked = 0;
    RST_N <= 1'b0;
    repeat (2) @(posedge CLK);
    RST_N <= 1'b1;
    rd(8'h88, 0, q);
    check(q, 32'h000000e5);
    rd(8'h80, 1, q);
    check(q, 32'h00001030);
    // host reads the advertised sixteen words, then one word past the table end
    for (int i = 0; i < 16; i++) begin
      rd(8'h30 + 8'(4 * i), i % 3, q);
      check(q, EXP_W[i]);
    end
    rd(8'h70, 0, q);
    check(q, 32'h00000000);
    // table is read only
    wr(8'h30, 4'hf, 32'h00000000);
    rd(8'h30, 0, q);
    check(q, 32'hfff920e5);
    // stream whole table byte by byte, low byte first
    wr(8'h84, 4'h1, 32'h00000030);
    rd(8'h84, 0, q);
    check(q, 32'h00000030);
    for (int i = 0; i < 64; i++) begin
      rd(8'h88, i % 2, q);
      check(q, {24'h000000, EXP_W[i / 4][8 * (i % 4) +: 8]});
    end
    // pointer write without byte enable is ignored
    wr(8'h84, 4'he, 32'h0000006e);
    rd(8'h84, 0, q);
    check(q, 32'h00000070);
    // stream across the table end
    wr(8'h84, 4'h1, 32'h0000006e);
    for (int i = 0; i < 3; i++) begin
      rd(8'h88, 0, q);
      check(q, 32'h000000ff);
    end
    rd(8'h84, 0, q);
    check(q, 32'h00000071);
    // second reset brings the pointer back to the table start
    @(posedge CLK);
    RST_N <= 1'b0;
    repeat (2) @(posedge CLK);
    RST_N <= 1'b1;
    rd(8'h84, 0, q);
    check(q, 32'h00000030);
    rd(8'h88, 2, q);
    check(q, 32'h000000e5);
    check(32'(host_u.timeouts), 32'h00000000);
    summarize();
  end
endmodule : flash_parameter_table_rom_tb
